// ---- bench/tb_rps_profile_bank.sv ----
// self-checking testbench for the reference profile register set
`timescale 1ns/1ps
module tb_rps_profile_bank
	import rps_pkg::*;
;
	// ==========================================================
	// signals
	logic        clock, arst_n, write, read, ref_active, too_small;
	logic [11:0] addr;
	logic [7:0]  wdata, rdata, ph_fill, ph_drain, fr_fill, fr_drain;
	logic [2:0]  rank, alpha_exp2, sel, prom;
	logic [49:0] period;
	logic [19:0] inner_tol, outer_tol;
	logic [15:0] valid_ms, redetect_ms, alpha_lin, ph_thresh;
	logic [5:0]  alpha_exp1;
	logic [3:0]  alpha_exp3;
	logic [16:0] beta_lin, gamma_lin;
	logic [4:0]  beta_exp, gamma_exp, delta_exp;
	logic [14:0] delta_lin;
	logic [30:0] in_div, fb_div;
	logic [9:0]  frac_v, frac_u;
	logic [23:0] fr_thresh;
	logic [29:0] val;
	logic [7:0]  m [0:49];
	logic [11:0] odd [0:5] = '{12'h6b1, 12'h6e4, 12'h6ff, 12'h700, 12'h000, 12'hfff};
	integer      seed, fails, check_count, i, k;

	rps_profile_bank i_rps_profile_bank (
		.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WRITE(write), .READ(read),
		.RDATA(rdata), .REF_ACTIVE(ref_active), .RANK_PRIORITY(rank), .PERIOD_FS(period),
		.INNER_TOL(inner_tol), .OUTER_TOL(outer_tol), .VALID_MS(valid_ms), .REDETECT_MS(redetect_ms),
		.ALPHA_LIN(alpha_lin), .ALPHA_EXP1(alpha_exp1), .ALPHA_EXP2(alpha_exp2), .ALPHA_EXP3(alpha_exp3),
		.BETA_LIN(beta_lin), .BETA_EXP(beta_exp), .GAMMA_LIN(gamma_lin), .GAMMA_EXP(gamma_exp),
		.DELTA_LIN(delta_lin), .DELTA_EXP(delta_exp), .IN_DIV_RATIO(in_div), .FB_DIV_RATIO(fb_div),
		.FB_FRAC_V(frac_v), .FB_FRAC_U(frac_u), .PH_THRESH_PS(ph_thresh), .PH_FILL(ph_fill),
		.PH_DRAIN(ph_drain), .FR_THRESH_PS(fr_thresh), .FR_FILL(fr_fill), .FR_DRAIN(fr_drain),
		.FB_INT_TOO_SMALL(too_small)
	);

	always #10 clock = ~clock;

	// ==========================================================
	// compare tasks and expectation helpers
	task automatic check_byte(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_field(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// unused bits never stick, so the mirror keeps only writable ones
	function automatic logic [7:0] mask_of(input int idx);
		case (idx)
			0, 26, 33, 37, 40: mask_of = 8'h3f;
			7: mask_of = 8'h03;
			10, 13: mask_of = 8'h0f;
			23: mask_of = 8'h7f;
			39: mask_of = 8'hf3;
			default: mask_of = 8'hff;
		endcase
	endfunction

	// ==========================================================
	// bus tasks: strobes raised right after an edge, one cycle each
	task automatic bus_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		read <= 1'b0;
	endtask

	task automatic put(input int idx, input logic [7:0] d);
		bus_write(OFS_PRIORITY + 12'(idx), d);
		m[idx] = d & mask_of(idx);
	endtask

	task automatic bus_read(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		read <= 1'b1;
		write <= 1'b0;
		@(posedge clock);
		read <= 1'b0;
		#1;
		check_byte("rdata", rdata, exp);
	endtask

	// field outputs follow a write two edges later
	task automatic settle();
		@(posedge clock);
		write <= 1'b0;
		read <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic check_all();
		check_field("rank", rank, ref_active ? m[0][5:3] : m[0][2:0]);
		check_field("period", period, {m[7][1:0], m[6], m[5], m[4], m[3], m[2], m[1]});
		check_field("tol", {outer_tol, inner_tol}, {m[13][3:0], m[12], m[11], m[10][3:0], m[9], m[8]});
		check_field("timers", {redetect_ms, valid_ms}, {m[17], m[16], m[15], m[14]});
		check_field("alpha", {alpha_lin, alpha_exp1, alpha_exp2, alpha_exp3},
			{m[19], m[18], m[20][5:0], m[21][0], m[20][7:6], m[29][7:4]});
		check_field("beta", {beta_lin, beta_exp}, {m[23][1:0], m[22], m[21][7:1], m[23][6:2]});
		check_field("gamma", {gamma_lin, gamma_exp}, {m[26][0], m[25], m[24], m[26][5:1]});
		check_field("delta", {delta_lin, delta_exp}, {m[28][6:0], m[27], m[29][3:0], m[28][7]});
		check_field("in_div", in_div, 31'({m[33][5:0], m[32], m[31], m[30]}) + 31'd1);
		check_field("fb_div", fb_div, 31'({m[37][5:0], m[36], m[35], m[34]}) + 31'd1);
		check_field("too_small", too_small, {m[37][5:0], m[36], m[35], m[34]} < 30'd7);
		check_field("frac", {frac_u, frac_v}, {m[40][5:0], m[39][7:4], m[39][1:0], m[38]});
		check_field("phase", {ph_thresh, ph_fill, ph_drain}, {m[42], m[41], m[43], m[44]});
		check_field("freq", {fr_thresh, fr_fill, fr_drain}, {m[47], m[46], m[45], m[48], m[49]});
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		addr = 12'h000;
		wdata = 8'h00;
		write = 1'b0;
		read = 1'b0;
		ref_active = 1'b0;
		fails = 0;
		check_count = 0;
		seed = 32'h7c6d;
		for (i = 0; i < 50; i++) m[i] = 8'h00;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		settle();
		check_all();
		// fill every location back to back, then read all of it
		for (i = 0; i < 50; i++) put(i, 8'($random(seed)));
		settle();
		check_all();
		for (i = 0; i < 50; i++) bus_read(OFS_PRIORITY + 12'(i), m[i]);
		// places outside the profile ignore writes and read zero
		for (i = 0; i < 6; i++) bus_write(odd[i], 8'($random(seed)));
		for (i = 0; i < 6; i++) bus_read(odd[i], 8'h00);
		settle();
		check_all();
		// read right behind a write, then the data drop back to zero
		put(30, 8'($random(seed)));
		bus_read(OFS_IN_DIV, m[30]);
		@(posedge clock);
		#1;
		check_byte("rdata idle", rdata, 8'h00);
		// software keeps promoted not above selection
		for (k = 0; k < 16; k++) begin
			sel = 3'($random(seed));
			prom = 3'({$random(seed)} % (sel + 1));
			put(0, {2'($random(seed)), prom, sel});
			ref_active <= 1'($random(seed));
			settle();
			check_all();
		end
		// feedback values from the smallest legal one up
		for (k = 0; k < 4; k++) begin
			val = (k == 3) ? 30'h3fffffff : 30'(k + 7);
			for (i = 0; i < 4; i++) put(34 + i, 8'(val >> (8 * i)));
			for (i = 0; i < 4; i++) put(30 + i, 8'(~val >> (8 * i)));
			settle();
			check_all();
		end
		for (k = 0; k < 200; k++) begin
			put({$random(seed)} % 50, 8'($random(seed)));
			if (k % 25 == 24) begin
				settle();
				check_all();
			end
		end
		// a second reset in mid-run clears every byte
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		for (i = 0; i < 50; i++) m[i] = 8'h00;
		settle();
		check_all();
		bus_read(OFS_PERIOD, 8'h00);
		report_and_stop();
	end

	// ==========================================================
	// watchdog, well beyond the roughly 565 cycles the run needs
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		report_and_stop();
	end
endmodule

// ---- logic/rps_byte_cell.sv ----
// one profile byte location with its writable-bit mask
`timescale 1ns/1ps
module rps_byte_cell
	import rps_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hff
) (
	input  wire logic       clock,    // system clock
	input  wire logic       arst_n,   // async reset, active low
	input  wire logic       write_en, // write strobe for this byte
	input  wire logic [7:0] wdata,    // write data
	output logic      [7:0] value     // stored value, unused bits zero
);
	// unused bits are never stored, so they read back as zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			value <= BYTE_RESET;
		end else if (write_en) begin
			value <= wdata & MASK;
		end
	end
endmodule

// ---- logic/rps_profile_bank.sv ----
// reference profile register set: storage, bus slave and field outputs
// ==========================================================
// What this block does
// - holds 3-bit selection priority that ranks this reference.
// - holds 3-bit promoted priority, used only while reference is active.
// - stores 50-bit nominal period in femtoseconds over seven bytes, low first.
// - input divider ratio is stored 30-bit value plus one.
// - integer feedback divider ratio is stored 30-bit value plus one.
// - each filter coefficient is fraction times two to an exponent.
// - each exponent field is an integer power-of-two shift.
// - alpha has 16-bit linear, 6-, 3- and 4-bit exponents.
// - beta has 17-bit linear over three bytes and 5-bit exponent.
// - gamma linear bit 16 in third byte bit 0, exponent bits 5:1.
// - delta has 15-bit linear and split 5-bit exponent.
// - phase lock threshold is 16-bit picoseconds, low byte first.
// - phase lock fill and drain rates are separate bytes.
// - frequency lock threshold is 24-bit picoseconds, low byte first.
// - frequency lock fill and drain rates follow the threshold.
`timescale 1ns/1ps
module rps_profile_bank
	import rps_pkg::*;
(
	input  wire logic        CLOCK,            // 50 MHz system clock
	input  wire logic        ARST_N,           // async reset, active low
	input  wire logic [11:0] ADDR,             // register byte address
	input  wire logic [7:0]  WDATA,            // write data
	input  wire logic        WRITE,            // write strobe
	input  wire logic        READ,             // read strobe
	output logic      [7:0]  RDATA,            // read data, cycle after READ
	input  wire logic        REF_ACTIVE,       // this reference is active
	output logic      [2:0]  RANK_PRIORITY,    // priority used in selection
	output logic      [49:0] PERIOD_FS,        // nominal period
	output logic      [19:0] INNER_TOL,        // inner tolerance
	output logic      [19:0] OUTER_TOL,        // outer tolerance
	output logic      [15:0] VALID_MS,         // validation timer
	output logic      [15:0] REDETECT_MS,      // redetect timer
	output logic      [15:0] ALPHA_LIN,        // alpha linear fraction
	output logic      [5:0]  ALPHA_EXP1,       // alpha first exponent
	output logic      [2:0]  ALPHA_EXP2,       // alpha second exponent
	output logic      [3:0]  ALPHA_EXP3,       // alpha third exponent
	output logic      [16:0] BETA_LIN,         // beta linear fraction
	output logic      [4:0]  BETA_EXP,         // beta exponent
	output logic      [16:0] GAMMA_LIN,        // gamma linear fraction
	output logic      [4:0]  GAMMA_EXP,        // gamma exponent
	output logic      [14:0] DELTA_LIN,        // delta linear fraction
	output logic      [4:0]  DELTA_EXP,        // delta exponent
	output logic      [30:0] IN_DIV_RATIO,     // input divide ratio
	output logic      [30:0] FB_DIV_RATIO,     // feedback integer ratio
	output logic      [9:0]  FB_FRAC_V,        // fraction numerator field
	output logic      [9:0]  FB_FRAC_U,        // fraction denominator field
	output logic      [15:0] PH_THRESH_PS,     // phase lock threshold
	output logic      [7:0]  PH_FILL,          // phase lock fill rate
	output logic      [7:0]  PH_DRAIN,         // phase lock drain rate
	output logic      [23:0] FR_THRESH_PS,     // frequency lock threshold
	output logic      [7:0]  FR_FILL,          // frequency lock fill rate
	output logic      [7:0]  FR_DRAIN,         // frequency lock drain rate
	output logic             FB_INT_TOO_SMALL  // feedback value below seven
);
	// ==========================================================
	// address decode
	wire logic [11:0]            offset_rel = ADDR - OFS_PRIORITY;
	wire logic                   in_store   = (ADDR >= OFS_PRIORITY) && (ADDR < OFS_SPARE_FIRST);
	wire logic [5:0]             index      = offset_rel[5:0];
	wire logic [NUM_BYTES*8-1:0] bytes_flat;
	wire logic [7:0]             read_byte;
	rps_access_type              access;
	assign access = WRITE ? ACC_WRITE : (READ ? ACC_READ : ACC_IDLE);

	// ==========================================================
	// byte storage
	// masks per byte; spare space 6e4..6ff has no storage
	function automatic logic [7:0] byte_mask(input int i);
		logic [11:0] a;
		a = OFS_PRIORITY + 12'(i);
		case (a)
			OFS_PRIORITY:            byte_mask = MASK_PRIORITY;
			OFS_PERIOD + 12'h006:    byte_mask = MASK_TOP2;
			OFS_INNER_TOL + 12'h002: byte_mask = MASK_NIBBLE;
			OFS_OUTER_TOL + 12'h002: byte_mask = MASK_NIBBLE;
			OFS_FILTER + 12'h005:    byte_mask = MASK_SEVEN;
			OFS_FILTER + 12'h008:    byte_mask = MASK_SIX;
			OFS_IN_DIV + 12'h003:    byte_mask = MASK_SIX;
			OFS_FB_INT + 12'h003:    byte_mask = MASK_SIX;
			OFS_FB_FRAC + 12'h001:   byte_mask = MASK_FRAC_MID;
			OFS_FB_FRAC + 12'h002:   byte_mask = MASK_SIX;
			default:                 byte_mask = MASK_FULL;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_BYTES; g = g + 1) begin : g_cell
			wire logic hit_here = (access == ACC_WRITE) && in_store && (index == 6'(g));
			rps_byte_cell #(.MASK(byte_mask(g))) u_cell (
				.clock    (CLOCK),
				.arst_n   (ARST_N),
				.write_en (hit_here),
				.wdata    (WDATA),
				.value    (bytes_flat[g*8 +: 8])
			);
		end
	endgenerate

	rps_read_mux u_mux (
		.bytes_flat (bytes_flat),
		.hit        (in_store),
		.index      (index),
		.rdata      (read_byte)
	);

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= BYTE_RESET;
		end else begin
			RDATA <= (access == ACC_READ) ? read_byte : BYTE_RESET;
		end
	end

	// ==========================================================
	// field unpacking
	// byte positions of each field start inside the storage array
	localparam int P_PRIORITY = 0;
	localparam int P_PERIOD   = int'(OFS_PERIOD - OFS_PRIORITY);
	localparam int P_INNER    = int'(OFS_INNER_TOL - OFS_PRIORITY);
	localparam int P_OUTER    = int'(OFS_OUTER_TOL - OFS_PRIORITY);
	localparam int P_VALID    = int'(OFS_VALID_TIME - OFS_PRIORITY);
	localparam int P_REDET    = int'(OFS_REDETECT - OFS_PRIORITY);
	localparam int P_FILTER   = int'(OFS_FILTER - OFS_PRIORITY);
	localparam int P_IN_DIV   = int'(OFS_IN_DIV - OFS_PRIORITY);
	localparam int P_FB_INT   = int'(OFS_FB_INT - OFS_PRIORITY);
	localparam int P_FB_FRAC  = int'(OFS_FB_FRAC - OFS_PRIORITY);
	localparam int P_PH_TH    = int'(OFS_PH_THRESH - OFS_PRIORITY);
	localparam int P_PH_FILL  = int'(OFS_PH_FILL - OFS_PRIORITY);
	localparam int P_PH_DRAIN = int'(OFS_PH_DRAIN - OFS_PRIORITY);
	localparam int P_FR_TH    = int'(OFS_FR_THRESH - OFS_PRIORITY);
	localparam int P_FR_FILL  = int'(OFS_FR_FILL - OFS_PRIORITY);
	localparam int P_FR_DRAIN = int'(OFS_FR_DRAIN - OFS_PRIORITY);

	// plain byte view, so every field follows its bytes directly
	wire logic [7:0] pb [0:NUM_BYTES-1];
	generate
		for (g = 0; g < NUM_BYTES; g = g + 1) begin : g_byte
			assign pb[g] = bytes_flat[g*8 +: 8];
		end
	endgenerate

	wire logic [2:0]  sel_prio  = pb[P_PRIORITY][2:0];
	wire logic [2:0]  prom_prio = pb[P_PRIORITY][5:3];
	wire logic [2:0]  next_rank = REF_ACTIVE ? prom_prio : sel_prio;
	wire logic [49:0] next_period = {pb[P_PERIOD + 6][1:0], pb[P_PERIOD + 5], pb[P_PERIOD + 4],
		pb[P_PERIOD + 3], pb[P_PERIOD + 2], pb[P_PERIOD + 1], pb[P_PERIOD]};
	wire logic [19:0] next_inner = {pb[P_INNER + 2][3:0], pb[P_INNER + 1], pb[P_INNER]};
	wire logic [19:0] next_outer = {pb[P_OUTER + 2][3:0], pb[P_OUTER + 1], pb[P_OUTER]};
	wire logic [15:0] next_valid = {pb[P_VALID + 1], pb[P_VALID]};
	wire logic [15:0] next_redet = {pb[P_REDET + 1], pb[P_REDET]};
	wire logic [15:0] next_a_lin = {pb[P_FILTER + 1], pb[P_FILTER]};
	wire logic [5:0]  next_a_e1  = pb[P_FILTER + 2][5:0];
	wire logic [2:0]  next_a_e2  = {pb[P_FILTER + 3][0], pb[P_FILTER + 2][7:6]};
	wire logic [3:0]  next_a_e3  = pb[P_FILTER + 11][7:4];
	wire logic [16:0] next_b_lin = {pb[P_FILTER + 5][1:0], pb[P_FILTER + 4], pb[P_FILTER + 3][7:1]};
	wire logic [4:0]  next_b_exp = pb[P_FILTER + 5][6:2];
	wire logic [16:0] next_g_lin = {pb[P_FILTER + 8][0], pb[P_FILTER + 7], pb[P_FILTER + 6]};
	wire logic [4:0]  next_g_exp = pb[P_FILTER + 8][5:1];
	wire logic [14:0] next_d_lin = {pb[P_FILTER + 10][6:0], pb[P_FILTER + 9]};
	wire logic [4:0]  next_d_exp = {pb[P_FILTER + 11][3:0], pb[P_FILTER + 10][7]};
	wire logic [29:0] in_div = {pb[P_IN_DIV + 3][5:0], pb[P_IN_DIV + 2], pb[P_IN_DIV + 1], pb[P_IN_DIV]};
	wire logic [29:0] fb_int = {pb[P_FB_INT + 3][5:0], pb[P_FB_INT + 2], pb[P_FB_INT + 1], pb[P_FB_INT]};
	wire logic [9:0]  next_v = {pb[P_FB_FRAC + 1][1:0], pb[P_FB_FRAC]};
	wire logic [9:0]  next_u = {pb[P_FB_FRAC + 2][5:0], pb[P_FB_FRAC + 1][7:4]};
	wire logic [15:0] next_ph_th = {pb[P_PH_TH + 1], pb[P_PH_TH]};
	wire logic [23:0] next_fr_th = {pb[P_FR_TH + 2], pb[P_FR_TH + 1], pb[P_FR_TH]};

	// ==========================================================
	// registered outputs
	// coefficients leave as separate linear and exponent fields so the
	// filter applies the shift itself; saves a wide barrel shifter here
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			RANK_PRIORITY <= 3'h0;
			PERIOD_FS     <= 50'h0;
			INNER_TOL     <= 20'h0;
			OUTER_TOL     <= 20'h0;
			VALID_MS      <= 16'h0;
			REDETECT_MS   <= 16'h0;
		end else begin
			RANK_PRIORITY <= next_rank;
			PERIOD_FS     <= next_period;
			INNER_TOL     <= next_inner;
			OUTER_TOL     <= next_outer;
			VALID_MS      <= next_valid;
			REDETECT_MS   <= next_redet;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ALPHA_LIN  <= 16'h0;
			ALPHA_EXP1 <= 6'h0;
			ALPHA_EXP2 <= 3'h0;
			ALPHA_EXP3 <= 4'h0;
			BETA_LIN   <= 17'h0;
			BETA_EXP   <= 5'h0;
			GAMMA_LIN  <= 17'h0;
			GAMMA_EXP  <= 5'h0;
			DELTA_LIN  <= 15'h0;
			DELTA_EXP  <= 5'h0;
		end else begin
			ALPHA_LIN  <= next_a_lin;
			ALPHA_EXP1 <= next_a_e1;
			ALPHA_EXP2 <= next_a_e2;
			ALPHA_EXP3 <= next_a_e3;
			BETA_LIN   <= next_b_lin;
			BETA_EXP   <= next_b_exp;
			GAMMA_LIN  <= next_g_lin;
			GAMMA_EXP  <= next_g_exp;
			DELTA_LIN  <= next_d_lin;
			DELTA_EXP  <= next_d_exp;
		end
	end

	// ratio is stored value plus one
	// same for feedback; flagged, not corrected
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			IN_DIV_RATIO     <= 31'h1;
			FB_DIV_RATIO     <= 31'h1;
			FB_INT_TOO_SMALL <= 1'b1;
			FB_FRAC_V        <= 10'h0;
			FB_FRAC_U        <= 10'h0;
		end else begin
			IN_DIV_RATIO     <= {1'b0, in_div} + 31'h1;
			FB_DIV_RATIO     <= {1'b0, fb_int} + 31'h1;
			FB_INT_TOO_SMALL <= fb_int < FB_INT_MIN;
			FB_FRAC_V        <= next_v;
			FB_FRAC_U        <= next_u;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PH_THRESH_PS <= 16'h0;
			PH_FILL      <= 8'h0;
			PH_DRAIN     <= 8'h0;
			FR_THRESH_PS <= 24'h0;
			FR_FILL      <= 8'h0;
			FR_DRAIN     <= 8'h0;
		end else begin
			PH_THRESH_PS <= next_ph_th;
			PH_FILL      <= pb[P_PH_FILL];
			PH_DRAIN     <= pb[P_PH_DRAIN];
			FR_THRESH_PS <= next_fr_th;
			FR_FILL      <= pb[P_FR_FILL];
			FR_DRAIN     <= pb[P_FR_DRAIN];
		end
	end

	// ==========================================================
	// checks
	// write masks, spare read zero
	AST_SPARE_ZERO: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		READ && !in_store |=> RDATA == 8'h00) else $error("unmapped read not zero");
	AST_READ_BACK: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && in_store ##1 READ && ADDR == $past(ADDR) |=> RDATA == ($past(WDATA, 2) & byte_mask(32'($past(index, 2)))))
		else $error("read back mismatch");
	AST_RANK_SEL: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		!REF_ACTIVE |=> RANK_PRIORITY == $past(sel_prio)) else $error("selection rank wrong");
	AST_RANK_PROM: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		REF_ACTIVE |=> RANK_PRIORITY == $past(prom_prio)) else $error("promoted rank wrong");
	AST_IN_DIV: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		##1 IN_DIV_RATIO == {1'b0, $past(in_div)} + 31'h1) else $error("input ratio wrong");
	AST_FB_DIV: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		##1 FB_DIV_RATIO == {1'b0, $past(fb_int)} + 31'h1) else $error("feedback ratio wrong");
	AST_PERIOD_TOP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_PERIOD + 12'h006 |-> ##2 PERIOD_FS[49:48] == $past(WDATA[1:0], 2))
		else $error("period top bits wrong");
	AST_GAMMA_EXP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FILTER + 12'h008 |-> ##2 GAMMA_EXP == $past(WDATA[5:1], 2))
		else $error("gamma exponent wrong");
	AST_DELTA_EXP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FILTER + 12'h00a |-> ##2 DELTA_EXP[0] == $past(WDATA[7], 2))
		else $error("delta exponent bit wrong");
	AST_RDATA_IDLE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		!READ |=> RDATA == 8'h00) else $error("read data not idle");
	AST_FB_SMALL: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		##1 FB_INT_TOO_SMALL == ($past(fb_int) < FB_INT_MIN)) else $error("small feedback flag wrong");
	AST_PRIO_WRITE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_PRIORITY |-> ##2
		RANK_PRIORITY == ($past(REF_ACTIVE) ? $past(WDATA[5:3], 2) : $past(WDATA[2:0], 2)))
		else $error("rank after priority write wrong");
	AST_PERIOD_LOW: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_PERIOD |-> ##2 PERIOD_FS[7:0] == $past(WDATA, 2))
		else $error("period low byte wrong");
	AST_INNER_TOP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_INNER_TOL + 12'h002 |-> ##2 INNER_TOL[19:16] == $past(WDATA[3:0], 2))
		else $error("inner tolerance top bits wrong");
	AST_ALPHA_EXP2: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FILTER + 12'h003 |-> ##2 ALPHA_EXP2[2] == $past(WDATA[0], 2))
		else $error("alpha second exponent bit wrong");
	AST_BETA_LOW: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FILTER + 12'h003 |-> ##2 BETA_LIN[6:0] == $past(WDATA[7:1], 2))
		else $error("beta linear low bits wrong");
	AST_BETA_EXP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FILTER + 12'h005 |-> ##2 BETA_EXP == $past(WDATA[6:2], 2))
		else $error("beta exponent wrong");
	AST_GAMMA_TOP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FILTER + 12'h008 |-> ##2 GAMMA_LIN[16] == $past(WDATA[0], 2))
		else $error("gamma linear top bit wrong");
	AST_FRAC_MID: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FB_FRAC + 12'h001 |-> ##2
		FB_FRAC_U[3:0] == $past(WDATA[7:4], 2) && FB_FRAC_V[9:8] == $past(WDATA[1:0], 2))
		else $error("fraction middle byte wrong");
	AST_PH_TH_TOP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_PH_THRESH + 12'h001 |-> ##2 PH_THRESH_PS[15:8] == $past(WDATA, 2))
		else $error("phase threshold high byte wrong");
	AST_PH_FILL: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_PH_FILL |-> ##2 PH_FILL == $past(WDATA, 2))
		else $error("phase fill rate wrong");
	AST_FR_TH_TOP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FR_THRESH + 12'h002 |-> ##2 FR_THRESH_PS[23:16] == $past(WDATA, 2))
		else $error("frequency threshold top byte wrong");
	AST_FR_DRAIN: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		WRITE && ADDR == OFS_FR_DRAIN |-> ##2 FR_DRAIN == $past(WDATA, 2))
		else $error("frequency drain rate wrong");
	COV_WRITE_READ: cover property (@(posedge CLOCK) WRITE && in_store ##1 READ);
	COV_ACTIVE_SWAP: cover property (@(posedge CLOCK) !REF_ACTIVE ##1 REF_ACTIVE);
	COV_SMALL_FB: cover property (@(posedge CLOCK) FB_INT_TOO_SMALL ##1 !FB_INT_TOO_SMALL);
endmodule

// ---- logic/rps_read_mux.sv ----
// read data selection for the profile byte array
`timescale 1ns/1ps
module rps_read_mux
	import rps_pkg::*;
(
	input  wire logic [NUM_BYTES*8-1:0] bytes_flat, // all profile bytes
	input  wire logic                   hit,        // address inside storage
	input  wire logic [5:0]             index,      // byte index
	output logic      [7:0]             rdata       // selected byte or zero
);
	assign rdata = hit ? bytes_flat[index*8 +: 8] : BYTE_RESET;
endmodule

// ---- shared/rps_pkg.sv ----
// constants and types for the reference profile register set
package rps_pkg;
	// ==========================================================
	// address map
	localparam logic [11:0] ADDR_WIDTH_TOP   = 12'hfff;
	localparam logic [11:0] OFS_PRIORITY     = 12'h6b2;
	localparam logic [11:0] OFS_PERIOD       = 12'h6b3;
	localparam logic [11:0] OFS_INNER_TOL    = 12'h6ba;
	localparam logic [11:0] OFS_OUTER_TOL    = 12'h6bd;
	localparam logic [11:0] OFS_VALID_TIME   = 12'h6c0;
	localparam logic [11:0] OFS_REDETECT     = 12'h6c2;
	localparam logic [11:0] OFS_FILTER       = 12'h6c4;
	localparam logic [11:0] OFS_IN_DIV       = 12'h6d0;
	localparam logic [11:0] OFS_FB_INT       = 12'h6d4;
	localparam logic [11:0] OFS_FB_FRAC      = 12'h6d8;
	localparam logic [11:0] OFS_PH_THRESH    = 12'h6db;
	localparam logic [11:0] OFS_PH_FILL      = 12'h6dd;
	localparam logic [11:0] OFS_PH_DRAIN     = 12'h6de;
	localparam logic [11:0] OFS_FR_THRESH    = 12'h6df;
	localparam logic [11:0] OFS_FR_FILL      = 12'h6e2;
	localparam logic [11:0] OFS_FR_DRAIN     = 12'h6e3;
	localparam logic [11:0] OFS_SPARE_FIRST  = 12'h6e4;
	localparam logic [11:0] OFS_SPARE_LAST   = 12'h6ff;
	// ==========================================================
	// storage shape
	localparam int          NUM_BYTES        = 50;
	localparam logic [5:0]  LAST_BYTE_INDEX  = 6'h31;
	localparam logic [7:0]  BYTE_RESET       = 8'h00;
	// writable bit masks; all but MASK_FULL are for bytes that hold unused bits
	localparam logic [7:0]  MASK_PRIORITY    = 8'h3f;
	localparam logic [7:0]  MASK_TOP2        = 8'h03;
	localparam logic [7:0]  MASK_NIBBLE      = 8'h0f;
	localparam logic [7:0]  MASK_SEVEN       = 8'h7f;
	localparam logic [7:0]  MASK_SIX         = 8'h3f;
	localparam logic [7:0]  MASK_FRAC_MID    = 8'hf3;
	localparam logic [7:0]  MASK_FULL        = 8'hff;
	// smallest legal integer feedback value
	localparam logic [29:0] FB_INT_MIN       = 30'h0000007;
	// bus access state
	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_READ  = 2'b11
	} rps_access_type;
endpackage
